// *** hdl/tprc_regs.v ***
`include "tprc_map.vh"

module tprc_regs #(
    parameter [`TPRC_DLY_W-1:0] DLY1_CYC = `TPRC_DLY1_CYC,
    parameter [`TPRC_DLY_W-1:0] DLY2_CYC = `TPRC_DLY2_CYC,
    parameter [`TPRC_DLY_W-1:0] DLY3_CYC = `TPRC_DLY3_CYC
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        reset_n,
    // Serial port pins
    input  wire        spi_sclk,
    input  wire        spi_cs_n,
    input  wire        spi_mosi,
    output reg         spi_miso,
    output reg         spi_miso_oe_n,
    // Converter sequencer side
    input  wire        conv_active,
    input  wire        data_ready_pin,
    output reg         ref_power_on,
    output reg         ref_settled,
    output reg         ref_use_internal,
    output reg         ref_voltage_select,
    output reg  [2:0]  precharge_time_sel,
    output reg  [2:0]  sense_time_sel,
    output reg         keypad_ctrl_bit,
    // PLL and pin routing
    output reg         pll_to_pin_sel,
    output reg         pll_manual_enable,
    output reg  [3:0]  pll_predivider,
    output reg  [3:0]  pll_frac_term,
    output reg  [3:0]  pll_mult_term
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    reg  [2:0]  sclk_sync_q;
    reg  [1:0]  cs_sync_q;
    reg  [1:0]  mosi_sync_q;
    wire        sclk_rise;
    wire        sclk_fall;
    wire        cs_idle;
    wire        mosi_bit;

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync_q <= 3'h0;
            cs_sync_q   <= 2'h3;
            mosi_sync_q <= 2'h0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], spi_sclk};
            cs_sync_q   <= {cs_sync_q[0], spi_cs_n};
            mosi_sync_q <= {mosi_sync_q[0], spi_mosi};
        end
    end

    assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
    assign sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
    assign cs_idle   = cs_sync_q[1];
    assign mosi_bit  = mosi_sync_q[1];

    // ************************************************************
    // Register state
    // ************************************************************
    reg  [4:0]  ref_q;
    reg  [5:0]  tdt_q;
    reg         kbc_q;
    reg         pin_route_q;
    reg         auto_pll_q;
    reg  [3:0]  pdiv_q;
    reg  [3:0]  frac_q;
    reg  [3:0]  mult_q;

    // ************************************************************
    // Address decode and read mux
    // ************************************************************
    function hit;
        input [15:0] cmd;
        input [5:0]  addr;
        begin
            hit = (cmd[`TPRC_CMD_PAGE_HI:`TPRC_CMD_PAGE_LO] == `TPRC_CFG_PAGE) &&
                  (cmd[`TPRC_CMD_ADDR_HI:`TPRC_CMD_ADDR_LO] == addr);
        end
    endfunction

    reg  [15:0] rd_word;
    reg  [15:0] shift_q;
    wire [15:0] word_in;

    assign word_in = {shift_q[14:0], mosi_bit};

    always @* begin
        rd_word = 16'h0000;
        if (hit(word_in, `TPRC_REF_ADDR)) begin
            rd_word = {11'h000, ref_q};
        end else if (hit(word_in, `TPRC_TDT_ADDR)) begin
            rd_word = {10'h000, tdt_q};
        end else if (hit(word_in, `TPRC_SEC_ADDR)) begin
            rd_word = {data_ready_pin, 1'h0, pin_route_q, auto_pll_q, pdiv_q, frac_q, mult_q};
        end
    end

    // ************************************************************
    // Serial frame: one command word, then one data word
    // ************************************************************
    reg  [4:0]  bit_cnt_q;
    reg  [15:0] cmd_q;
    reg  [15:0] tx_q;
    wire        data_phase;
    wire        wr_en;

    assign data_phase = bit_cnt_q[4];
    assign wr_en      = ~cs_idle & sclk_rise & (bit_cnt_q == 5'h1f) &
                        ~cmd_q[`TPRC_CMD_RD_BIT];

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_q     <= 5'h00;
            shift_q       <= 16'h0000;
            cmd_q         <= 16'h0000;
            tx_q          <= 16'h0000;
            spi_miso      <= 1'h0;
            spi_miso_oe_n <= 1'h1;
        end else if (cs_idle) begin
            bit_cnt_q     <= 5'h00;
            spi_miso_oe_n <= 1'h1;
        end else begin
            spi_miso_oe_n <= ~(data_phase & cmd_q[`TPRC_CMD_RD_BIT]);
            if (sclk_rise) begin
                shift_q   <= word_in;
                bit_cnt_q <= bit_cnt_q + 5'h01;
                if (bit_cnt_q == 5'h0f) begin
                    cmd_q <= word_in;
                    tx_q  <= rd_word;
                end
            end
            if (sclk_fall && data_phase && cmd_q[`TPRC_CMD_RD_BIT]) begin
                spi_miso <= tx_q[15];
                tx_q     <= {tx_q[14:0], 1'h0};
            end
        end
    end

    // ************************************************************
    // Register writes
    // ************************************************************
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_q       <= `TPRC_REF_RST;
            tdt_q       <= `TPRC_TDT_RST;
            kbc_q       <= `TPRC_KBC_RST;
            pin_route_q <= `TPRC_ROUTE_RST;
            auto_pll_q  <= `TPRC_AUTO_RST;
            pdiv_q      <= `TPRC_PLL_NIB_RST;
            frac_q      <= `TPRC_PLL_NIB_RST;
            mult_q      <= `TPRC_PLL_NIB_RST;
        end else if (wr_en) begin
            if (hit(cmd_q, `TPRC_REF_ADDR)) begin
                ref_q <= word_in[4:0];
            end
            if (hit(cmd_q, `TPRC_TDT_ADDR)) begin
                tdt_q <= word_in[5:0];
            end
            if (hit(cmd_q, `TPRC_SEC_ADDR)) begin
                kbc_q       <= word_in[`TPRC_SEC_READY_BIT];
                pin_route_q <= word_in[`TPRC_SEC_ROUTE_BIT];
                auto_pll_q  <= word_in[`TPRC_SEC_AUTO_BIT];
                pdiv_q      <= word_in[`TPRC_SEC_P_HI:`TPRC_SEC_P_LO];
                frac_q      <= word_in[`TPRC_SEC_A_HI:`TPRC_SEC_A_LO];
                mult_q      <= word_in[`TPRC_SEC_N_HI:`TPRC_SEC_N_LO];
            end
        end
    end

    // ************************************************************
    // Reference power control and settling timer
    // ************************************************************
    reg  [`TPRC_DLY_W-1:0] dly_cnt_q;
    reg  [`TPRC_DLY_W-1:0] dly_load;
    reg                    ref_on_d;

    always @* begin
        case (ref_q[`TPRC_REF_DLY_HI:`TPRC_REF_DLY_LO])
            2'h1:    dly_load = DLY1_CYC;
            2'h2:    dly_load = DLY2_CYC;
            2'h3:    dly_load = DLY3_CYC;
            default: dly_load = {`TPRC_DLY_W{1'b0}};
        endcase
        ref_on_d = ref_q[`TPRC_REF_INT_BIT] &
                   (~ref_q[`TPRC_REF_SLEEP_BIT] | conv_active);
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_power_on <= 1'h0;
            ref_settled  <= 1'h0;
            dly_cnt_q    <= {`TPRC_DLY_W{1'b0}};
        end else begin
            ref_power_on <= ref_on_d;
            if (ref_on_d && !ref_power_on) begin
                dly_cnt_q   <= dly_load;
                ref_settled <= 1'h0;
            end else if (!ref_power_on) begin
                ref_settled <= 1'h0;
            end else if (dly_cnt_q != {`TPRC_DLY_W{1'b0}}) begin
                dly_cnt_q   <= dly_cnt_q - {{(`TPRC_DLY_W-1){1'b0}}, 1'b1};
                ref_settled <= 1'h0;
            end else begin
                ref_settled <= 1'h1;
            end
        end
    end

    // ************************************************************
    // Configuration outputs
    // ************************************************************
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_use_internal   <= 1'h0;
            ref_voltage_select <= 1'h0;
            precharge_time_sel <= 3'h0;
            sense_time_sel     <= 3'h0;
            keypad_ctrl_bit    <= `TPRC_KBC_RST;
            pll_to_pin_sel     <= `TPRC_ROUTE_RST;
            pll_manual_enable  <= 1'h0;
            pll_predivider     <= `TPRC_PLL_NIB_RST;
            pll_frac_term      <= `TPRC_PLL_NIB_RST;
            pll_mult_term      <= `TPRC_PLL_NIB_RST;
        end else begin
            ref_use_internal   <= ref_q[`TPRC_REF_INT_BIT];
            ref_voltage_select <= ref_q[`TPRC_REF_VSEL_BIT];
            precharge_time_sel <= tdt_q[`TPRC_TDT_PRE_HI:`TPRC_TDT_PRE_LO];
            sense_time_sel     <= tdt_q[`TPRC_TDT_SENSE_HI:`TPRC_TDT_SENSE_LO];
            keypad_ctrl_bit    <= kbc_q;
            pll_to_pin_sel     <= pin_route_q;
            pll_manual_enable  <= ~auto_pll_q;
            pll_predivider     <= pdiv_q;
            pll_frac_term      <= frac_q;
            pll_mult_term      <= mult_q;
        end
    end

endmodule // tprc_regs

// *** shared/tprc_map.vh ***
`ifndef TPRC_MAP_VH
`define TPRC_MAP_VH

// ****************************************************************
// Serial command word layout
// ****************************************************************
`define TPRC_CMD_RD_BIT      15
`define TPRC_CMD_PAGE_HI     14
`define TPRC_CMD_PAGE_LO     11
`define TPRC_CMD_ADDR_HI     10
`define TPRC_CMD_ADDR_LO     5
`define TPRC_WORD_BITS       16

// ****************************************************************
// Register page and offsets
// ****************************************************************
`define TPRC_CFG_PAGE        4'h1
`define TPRC_REF_ADDR        6'h03
`define TPRC_TDT_ADDR        6'h05
`define TPRC_SEC_ADDR        6'h06

// ****************************************************************
// Field positions
// ****************************************************************
`define TPRC_REF_INT_BIT     4
`define TPRC_REF_DLY_HI      3
`define TPRC_REF_DLY_LO      2
`define TPRC_REF_SLEEP_BIT   1
`define TPRC_REF_VSEL_BIT    0
`define TPRC_TDT_PRE_HI      5
`define TPRC_TDT_PRE_LO      3
`define TPRC_TDT_SENSE_HI    2
`define TPRC_TDT_SENSE_LO    0
`define TPRC_SEC_READY_BIT   15
`define TPRC_SEC_ROUTE_BIT   13
`define TPRC_SEC_AUTO_BIT    12
`define TPRC_SEC_P_HI        11
`define TPRC_SEC_P_LO        8
`define TPRC_SEC_A_HI        7
`define TPRC_SEC_A_LO        4
`define TPRC_SEC_N_HI        3
`define TPRC_SEC_N_LO        0

// ****************************************************************
// Reset values
// ****************************************************************
`define TPRC_REF_RST         5'h02
`define TPRC_TDT_RST         6'h00
`define TPRC_ROUTE_RST       1'h1
`define TPRC_AUTO_RST        1'h1
`define TPRC_PLL_NIB_RST     4'hf
`define TPRC_KBC_RST         1'h0

// ****************************************************************
// Reference settling delays
// ****************************************************************
`define TPRC_CLK_MHZ         250
`define TPRC_DLY1_US         100
`define TPRC_DLY2_US         500
`define TPRC_DLY3_US         1000
// Cycle counts are the delays above times the clock rate, sized to the timer
`define TPRC_DLY1_CYC        20'd25000
`define TPRC_DLY2_CYC        20'd125000
`define TPRC_DLY3_CYC        20'd250000
`define TPRC_DLY_W           20

`endif

// *** verification/tprc_regs_properties.sv ***
module tprc_regs_properties #(
    parameter [19:0] DLY1_CYC = 20'd25000,
    parameter [19:0] DLY2_CYC = 20'd125000,
    parameter [19:0] DLY3_CYC = 20'd250000
) (
    // Clock and reset
    input wire        sys_clk,
    input wire        reset_n,
    // Serial select
    input wire        spi_cs_n,
    // Reference side
    input wire        conv_active,
    input wire        ref_power_on,
    input wire        ref_settled,
    input wire        ref_use_internal,
    input wire        ref_voltage_select,
    input wire [2:0]  precharge_time_sel,
    input wire [2:0]  sense_time_sel,
    input wire        keypad_ctrl_bit,
    // PLL side
    input wire        pll_to_pin_sel,
    input wire        pll_manual_enable,
    input wire [3:0]  pll_predivider,
    input wire [3:0]  pll_frac_term,
    input wire [3:0]  pll_mult_term
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // ****************************************************************
    // Cycles the reference has been powered
    // ****************************************************************
    logic [19:0] on_cnt_q;
    wire  [19:0] on_cnt_d = ref_power_on ? on_cnt_q + 20'h00001 : 20'h00000;
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            on_cnt_q <= 20'h00000;
        end else begin
            on_cnt_q <= on_cnt_d;
        end
    end

    sequence s_ref_drop;
        $fell(ref_power_on);
    endsequence
    sequence s_cs_idle;
        spi_cs_n [*8];
    endsequence

    a_off_when_ext: assert property (!ref_use_internal |-> !ref_power_on)
        else $error("reference on with external select");
    a_on_in_conv: assert property (ref_use_internal && $past(conv_active) |-> ref_power_on)
        else $error("reference off during conversion");
    a_drop_cause: assert property (s_ref_drop |-> !$past(conv_active) || !ref_use_internal)
        else $error("reference dropped while needed");
    a_drop_unsettle: assert property (s_ref_drop |=> !ref_settled)
        else $error("settled kept after power off");
    a_rise_unsettled: assert property ($rose(ref_power_on) |-> !ref_settled)
        else $error("settled at power up");
    a_settle_time: assert property ($rose(ref_settled) |-> on_cnt_q == 20'h00001
        || on_cnt_q == DLY1_CYC + 20'h00001 || on_cnt_q == DLY2_CYC + 20'h00001
        || on_cnt_q == DLY3_CYC + 20'h00001)
        else $error("settling delay length wrong");
    a_ref_hold: assert property (s_cs_idle |-> $stable({ref_use_internal, ref_voltage_select}))
        else $error("reference fields moved while idle");
    a_tdt_hold: assert property (s_cs_idle |-> $stable({precharge_time_sel, sense_time_sel}))
        else $error("timing codes moved while idle");
    a_pll_hold: assert property (s_cs_idle |-> $stable({pll_to_pin_sel, pll_manual_enable,
        pll_predivider, pll_frac_term, pll_mult_term, keypad_ctrl_bit}))
        else $error("pll fields moved while idle");
endmodule // tprc_regs_properties

bind tprc_regs tprc_regs_properties #(
    .DLY1_CYC(DLY1_CYC), .DLY2_CYC(DLY2_CYC), .DLY3_CYC(DLY3_CYC)
) u_props (
    .sys_clk, .reset_n, .spi_cs_n, .conv_active, .ref_power_on, .ref_settled,
    .ref_use_internal, .ref_voltage_select, .precharge_time_sel, .sense_time_sel,
    .keypad_ctrl_bit, .pll_to_pin_sel, .pll_manual_enable, .pll_predivider,
    .pll_frac_term, .pll_mult_term
);

// *** verification/tprc_host_model.sv ***
module tprc_host_model (
    // Clock
    input  wire        sys_clk,
    // Serial port
    output logic       spi_sclk,
    output logic       spi_cs_n,
    output logic       spi_mosi,
    input  wire        spi_miso,
    input  wire        spi_miso_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic miso_last_q = 1'b0;
    // Released line shows the inverse of its last driven level
    wire  miso_line = spi_miso_oe_n ? ~miso_last_q : spi_miso;
    initial spi_sclk = 1'b0;
    initial spi_cs_n = 1'b1;
    initial spi_mosi = 1'b0;
    always @(posedge sys_clk) if (!spi_miso_oe_n) miso_last_q <= spi_miso;

    // One 32-bit frame: command word then data word, MSB first
    task automatic xfer(input logic [15:0] cmd, input logic [15:0] wdat,
                        output logic [15:0] rdat);
        logic [31:0] frame;
        frame = {cmd, wdat};
        rdat = 16'h0000;
        @(posedge sys_clk) spi_cs_n <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            @(posedge sys_clk);
            spi_sclk <= 1'b0;
            spi_mosi <= frame[i];
            repeat (5) @(posedge sys_clk);
            if (i < 16) rdat[i] = miso_line;
            spi_sclk <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
        @(posedge sys_clk) spi_sclk <= 1'b0;
        repeat (5) @(posedge sys_clk);
        spi_cs_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule // tprc_host_model

// *** verification/test_tprc_regs.sv ***
`include "tprc_map.vh"
module test_tprc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] D1 = 20'd20;
    localparam logic [19:0] D2 = 20'd50;
    localparam logic [19:0] D3 = 20'd100;
    int   dly [4] = '{0, D1, D2, D3};
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic conv_active = 1'b0;
    logic data_ready_pin = 1'b1;
    wire  spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
    wire  ref_power_on, ref_settled, ref_use_internal, ref_voltage_select;
    wire  keypad_ctrl_bit, pll_to_pin_sel, pll_manual_enable;
    wire  [2:0] precharge_time_sel, sense_time_sel;
    wire  [3:0] pll_predivider, pll_frac_term, pll_mult_term;
    int   n_mismatch = 0;
    int   num_checks = 0;
    logic [15:0] rd;
    always #2 sys_clk = ~sys_clk;

    tprc_regs #(.DLY1_CYC(D1), .DLY2_CYC(D2), .DLY3_CYC(D3)) dut (
        .sys_clk, .reset_n, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n,
        .conv_active, .data_ready_pin, .ref_power_on, .ref_settled, .ref_use_internal,
        .ref_voltage_select, .precharge_time_sel, .sense_time_sel, .keypad_ctrl_bit,
        .pll_to_pin_sel, .pll_manual_enable, .pll_predivider, .pll_frac_term, .pll_mult_term
    );
    tprc_host_model host (.sys_clk, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n);

    // ****************************************************************
    // Access and compare tasks
    // ****************************************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        host.xfer({1'b0, `TPRC_CFG_PAGE, a, 5'h00}, d, rd);
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic rd_chk(input string what, input logic [5:0] a, input logic [15:0] exp);
        host.xfer({1'b1, `TPRC_CFG_PAGE, a, 5'h00}, 16'h0000, rd);
        check(what, rd, exp);
    endtask
    task automatic settle(input int exp);
        int n;
        n = 0;
        while (ref_power_on !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        while (ref_settled !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        check("settle_cycles", n[15:0], exp[15:0]);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd_chk("ref_rst", `TPRC_REF_ADDR, 16'h0002);
        rd_chk("tdt_rst", `TPRC_TDT_ADDR, 16'h0000);
        rd_chk("sec_rst", `TPRC_SEC_ADDR, 16'hbfff);
        check("pll_rst", {pll_to_pin_sel, pll_manual_enable, keypad_ctrl_bit, 1'b0,
              pll_predivider, pll_frac_term, pll_mult_term}, 16'h8fff);
        rd_chk("unmapped", 6'h04, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            logic [2:0] c;
            c = i[2:0];
            wr(`TPRC_TDT_ADDR, {10'h3ff, c, ~c});
            rd_chk("tdt", `TPRC_TDT_ADDR, {10'h000, c, ~c});
            check("tdt_out", {10'h000, precharge_time_sel, sense_time_sel}, {10'h000, c, ~c});
        end
        @(posedge sys_clk) data_ready_pin <= 1'b0;
        wr(`TPRC_SEC_ADDR, 16'hc579);
        rd_chk("sec_new", `TPRC_SEC_ADDR, 16'h0579);
        check("pll_out", {pll_to_pin_sel, pll_manual_enable, keypad_ctrl_bit, 1'b0,
              pll_predivider, pll_frac_term, pll_mult_term}, 16'h6579);
        @(posedge sys_clk) data_ready_pin <= 1'b1;
        wr(`TPRC_SEC_ADDR, 16'h3579);
        rd_chk("sec_idle", `TPRC_SEC_ADDR, 16'hb579);
        check("kbc_clr", {15'h0000, keypad_ctrl_bit}, 16'h0000);
        wr(`TPRC_REF_ADDR, 16'hffff);
        rd_chk("ref_all", `TPRC_REF_ADDR, 16'h001f);
        check("ref_out", {12'h000, ref_use_internal, ref_voltage_select, ref_power_on,
              ref_settled}, 16'h000c);
        for (int c = 0; c < 4; c++) begin
            logic [15:0] d;
            d = {12'h001, c[1:0], 2'b10};
            wr(`TPRC_REF_ADDR, d);
            rd_chk("ref_code", `TPRC_REF_ADDR, d);
            @(posedge sys_clk) conv_active <= 1'b1;
            settle(dly[c] + 1);
            @(posedge sys_clk) conv_active <= 1'b0;
            repeat (3) @(posedge sys_clk);
            check("ref_off", {14'h0000, ref_power_on, ref_settled}, 16'h0000);
        end
        wr(`TPRC_REF_ADDR, 16'h0004);
        @(posedge sys_clk) conv_active <= 1'b1;
        repeat (5) @(posedge sys_clk);
        check("ext_off", {15'h0000, ref_power_on}, 16'h0000);
        conv_active <= 1'b0;
        wr(`TPRC_REF_ADDR, 16'h0014);
        repeat (D1 + 5) @(posedge sys_clk);
        check("always_on", {14'h0000, ref_power_on, ref_settled}, 16'h0003);
        complete_run();
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        complete_run();
    end
endmodule // test_tprc_regs
